// file: src/acn_pkg.sv
// Constants and carrier types for the analog command conditioner
package acn_pkg;

    // Register indices (16-bit register numbers on the parameter port)
    localparam logic [15:0] ADDR_CORNER_FREQ   = 16'h0000;
    localparam logic [15:0] ADDR_DEAD_ZONE_TH  = 16'h0002;
    localparam logic [15:0] ADDR_CURRENT_SCALE = 16'h0004;
    localparam logic [15:0] ADDR_INPUT_OFFSET  = 16'h0006;
    localparam logic [15:0] ADDR_DEAD_ZONE_BHV = 16'h04A2;
    localparam logic [15:0] ADDR_FUNC_SELECT   = 16'h04A4;

    // Ranges and values after reset (Hz, mV, mA/V)
    localparam logic [13:0] CORNER_MAX         = 14'h2710;
    localparam logic [13:0] CORNER_RESET       = 14'h1388;
    localparam logic [13:0] DEAD_ZONE_MAX      = 14'h30D4;
    localparam logic [13:0] DEAD_ZONE_RESET    = 14'h0000;
    localparam logic [14:0] CURRENT_SCALE_MIN  = 15'h0001;
    localparam logic [14:0] CURRENT_SCALE_MAX  = 15'h5780;
    localparam logic [14:0] CURRENT_SCALE_RESET = 15'h0001;
    localparam logic [15:0] OFFSET_LIMIT       = 16'h2710;
    localparam logic [15:0] OFFSET_RESET       = 16'h0000;
    localparam logic        DEAD_ZONE_BHV_RESET = 1'b0;
    localparam logic [1:0]  FUNC_MAX           = 2'h2;
    localparam logic [1:0]  FUNC_RESET         = 2'h1;

    // Function, mode and source encodings
    localparam logic [1:0]  FUNC_OFF           = 2'h0;
    localparam logic [1:0]  FUNC_LOOP_CMD      = 2'h1;
    localparam logic [1:0]  FUNC_MOTION_VEL    = 2'h2;
    localparam logic [1:0]  OPMODE_TORQUE      = 2'h0;
    localparam logic [1:0]  OPMODE_VELOCITY    = 2'h1;
    localparam logic [1:0]  OPMODE_POSITION    = 2'h2;
    localparam logic [1:0]  SOURCE_SERVICE     = 2'h0;
    localparam logic [1:0]  SOURCE_ANALOG      = 2'h3;

    // Filter figures
    localparam real         BW_3DB_RATIO       = 0.64;
    localparam real         RISE_TIME_PRODUCT  = 0.53;

    // Timing: control sample rate derived from the 50 ns clock
    localparam int          CLK_PERIOD_NS      = 50;
    localparam int          SAMPLE_PERIOD_NS   = 16000;
    localparam int          SAMPLE_DIV         = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [8:0]  SAMPLE_DIV_LAST    = 9'(SAMPLE_DIV - 1);
    localparam int          COEF_SHIFT         = 10;
    // Q16 gain per Hz, scaled by 2^COEF_SHIFT: 2*pi*Ts*2^16*2^10
    localparam logic [12:0] COEF_PER_HZ        =
        13'($rtoi(6.283185307 * 65536.0 * 1024.0 * SAMPLE_PERIOD_NS / 1.0e9 + 0.5));

    typedef struct packed {
        logic [13:0]        corner_hz;
        logic [13:0]        dead_zone_mv;
        logic [14:0]        current_scale;
        logic signed [15:0] offset_mv;
        logic               dead_zone_bhv;
        logic [1:0]         func_select;
    } acn_settings_type;

    typedef struct packed {
        logic               valid;
        logic signed [31:0] value;
    } acn_cmd_type;

endpackage

// file: src/acn_pole.sv
// One first-order recursive low-pass section
`timescale 1ns/1ps
module acn_pole
    import acn_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               sample_en,
    input  wire logic [15:0]        coef,
    input  wire logic signed [15:0] x,
    output logic signed [15:0]      y
);
    // 16 integer and 16 fraction bits keep small steps from stalling the section
    logic signed [31:0] acc;
    logic signed [31:0] next_acc;
    logic signed [32:0] diff;
    logic signed [50:0] prod;
    logic signed [31:0] acc_rnd;

    always_comb begin
        // Sign bits extended by hand; a size cast of the concatenation would zero-fill negative inputs
        diff     = {x[15], x, 16'h0000} - {acc[31], acc};
        prod     = diff * $signed({1'b0, coef});
        next_acc = acc;
        if (sample_en) begin
            next_acc = acc + 32'(prod >>> 16);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 32'h00000000;
        end else begin
            acc <= next_acc;
        end
    end

    // Round to nearest: the floored step settles up to 65535/coef fraction LSBs short when rising
    // Cannot overflow, the accumulator never passes its target
    assign acc_rnd = acc + 32'sh00008000;
    assign y       = acc_rnd[31:16];
endmodule // acn_pole

// file: src/acn_conditioner.sv
// Analog command conditioner: offset, two-pole filter, dead zone, scaling, routing
`timescale 1ns/1ps
module acn_conditioner
    import acn_pkg::*;
(
    input  wire logic               REF_CLK,
    input  wire logic               RSTN,
    input  wire logic signed [15:0] AIN_SAMPLE,
    input  wire logic               REG_WR,
    input  wire logic [15:0]        REG_ADDR,
    input  wire logic [31:0]        REG_WDATA,
    output logic [31:0]             REG_RDATA,
    input  wire logic [1:0]         DRIVE_OPERATING_MODE,
    input  wire logic [1:0]         COMMAND_SOURCE_SELECT,
    input  wire logic signed [31:0] VELOCITY_SCALE_FACTOR,
    input  wire logic signed [31:0] POSITION_SCALE_FACTOR,
    input  wire logic signed [31:0] NEGATIVE_CURRENT_LIMIT,
    input  wire logic signed [31:0] POSITIVE_CURRENT_LIMIT,
    output logic signed [15:0]      AIN_FILTERED,
    output logic signed [31:0]      LOOP_CMD,
    output logic                    LOOP_CMD_VALID,
    output logic signed [31:0]      MOTION_VEL,
    output logic                    MOTION_VEL_VALID,
    output logic                    SAMPLE_TICK
);

    function automatic logic [15:0] coef_from_hz(input logic [13:0] hz);
        logic [26:0] p;
        p = 27'(hz) * 27'(COEF_PER_HZ);
        // Gain saturates just below one so the section never overshoots
        if ((p >> COEF_SHIFT) > 27'h000FFFF) begin
            coef_from_hz = 16'hFFFF;
        end else begin
            coef_from_hz = p[25:10];
        end
    endfunction

    function automatic logic signed [31:0] sat32(input logic signed [47:0] v);
        if (v > 48'sh00007FFFFFFF) begin
            sat32 = 32'sh7FFFFFFF;
        end else if (v < -48'sh000080000000) begin
            sat32 = 32'sh80000000;
        end else begin
            sat32 = v[31:0];
        end
    endfunction

    // Sample divider
    logic [8:0] div_cnt;
    logic [8:0] next_div_cnt;
    logic       sample_en;

    always_comb begin
        sample_en    = (div_cnt == SAMPLE_DIV_LAST);
        next_div_cnt = sample_en ? 9'h000 : div_cnt + 9'h001;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            div_cnt <= 9'h000;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // Settings registers; out-of-range writes are clamped, illegal selectors ignored
    acn_settings_type set;
    acn_settings_type next_set;
    logic [31:0]      next_rdata;
    logic [15:0]      coef;
    logic [15:0]      next_coef;

    always_comb begin
        next_set = set;
        if (REG_WR) begin
            case (REG_ADDR)
                ADDR_CORNER_FREQ: begin
                    next_set.corner_hz = (REG_WDATA > 32'(CORNER_MAX)) ? CORNER_MAX : REG_WDATA[13:0];
                end
                ADDR_DEAD_ZONE_TH: begin
                    next_set.dead_zone_mv = (REG_WDATA[15:0] > 16'(DEAD_ZONE_MAX)) ?
                                            DEAD_ZONE_MAX : REG_WDATA[13:0];
                end
                ADDR_CURRENT_SCALE: begin
                    if (REG_WDATA < 32'(CURRENT_SCALE_MIN)) begin
                        next_set.current_scale = CURRENT_SCALE_MIN;
                    end else if (REG_WDATA > 32'(CURRENT_SCALE_MAX)) begin
                        next_set.current_scale = CURRENT_SCALE_MAX;
                    end else begin
                        next_set.current_scale = REG_WDATA[14:0];
                    end
                end
                ADDR_INPUT_OFFSET: begin
                    if ($signed(REG_WDATA[15:0]) > $signed(OFFSET_LIMIT)) begin
                        next_set.offset_mv = OFFSET_LIMIT;
                    end else if ($signed(REG_WDATA[15:0]) < -$signed(OFFSET_LIMIT)) begin
                        next_set.offset_mv = -$signed(OFFSET_LIMIT);
                    end else begin
                        next_set.offset_mv = REG_WDATA[15:0];
                    end
                end
                ADDR_DEAD_ZONE_BHV: begin
                    if (REG_WDATA[15:0] <= 16'h0001) begin
                        next_set.dead_zone_bhv = REG_WDATA[0];
                    end
                end
                ADDR_FUNC_SELECT: begin
                    if (REG_WDATA[7:0] <= 8'(FUNC_MAX)) begin
                        next_set.func_select = REG_WDATA[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        case (REG_ADDR)
            ADDR_CORNER_FREQ:   next_rdata = 32'(set.corner_hz);
            ADDR_DEAD_ZONE_TH:  next_rdata = 32'(set.dead_zone_mv);
            ADDR_CURRENT_SCALE: next_rdata = 32'(set.current_scale);
            ADDR_INPUT_OFFSET:  next_rdata = {16'h0000, set.offset_mv};
            ADDR_DEAD_ZONE_BHV: next_rdata = 32'(set.dead_zone_bhv);
            ADDR_FUNC_SELECT:   next_rdata = 32'(set.func_select);
            default:            next_rdata = 32'h00000000;
        endcase
        next_coef = coef_from_hz(set.corner_hz);
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            set.corner_hz     <= CORNER_RESET;
            set.dead_zone_mv  <= DEAD_ZONE_RESET;
            set.current_scale <= CURRENT_SCALE_RESET;
            set.offset_mv     <= OFFSET_RESET;
            set.dead_zone_bhv <= DEAD_ZONE_BHV_RESET;
            set.func_select   <= FUNC_RESET;
            REG_RDATA         <= 32'h00000000;
            coef              <= 16'h0000;
        end else begin
            set       <= next_set;
            REG_RDATA <= next_rdata;
            coef      <= next_coef;
        end
    end

    // Offset, saturated to the sample range
    logic signed [16:0] offset_sum;
    logic signed [15:0] ain_trim;
    logic signed [15:0] pole1;
    logic signed [15:0] pole2;

    always_comb begin
        offset_sum = 17'(AIN_SAMPLE) + 17'(set.offset_mv);
        if (offset_sum > 17'sh07FFF) begin
            ain_trim = 16'sh7FFF;
        end else if (offset_sum < -17'sh08000) begin
            ain_trim = 16'sh8000;
        end else begin
            ain_trim = offset_sum[15:0];
        end
    end

    // Both sections share one coefficient so the poles stay coincident
    acn_pole u_pole1 (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .sample_en (sample_en),
        .coef      (coef),
        .x         (ain_trim),
        .y         (pole1)
    );

    acn_pole u_pole2 (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .sample_en (sample_en),
        .coef      (coef),
        .x         (pole1),
        .y         (pole2)
    );

    // Dead zone, scaling and routing
    logic signed [16:0] mag;
    logic signed [16:0] thr;
    logic signed [16:0] dz;
    logic signed [47:0] i_prod;
    logic signed [31:0] i_cmd;
    logic signed [31:0] v_cmd;
    logic signed [31:0] p_cmd;
    acn_cmd_type        loop_q;
    acn_cmd_type        next_loop;
    acn_cmd_type        mvel_q;
    acn_cmd_type        next_mvel;
    logic signed [15:0] filt_q;
    logic signed [15:0] next_filt;

    always_comb begin
        mag = (pole2 < 0) ? -17'(pole2) : 17'(pole2);
        thr = 17'(set.dead_zone_mv);
        if (set.dead_zone_bhv == 1'b0) begin
            dz = (mag < thr) ? 17'sh00000 : 17'(pole2);
        end else if (mag <= thr) begin
            dz = 17'sh00000;
        end else begin
            dz = (pole2 < 0) ? -(mag - thr) : (mag - thr);
        end
        // mV times mA/V gives microamperes, so no divider is needed
        i_prod = 48'(dz) * 48'($signed({1'b0, set.current_scale}));
        i_cmd  = sat32(i_prod);
        if (i_cmd > POSITIVE_CURRENT_LIMIT) begin
            i_cmd = POSITIVE_CURRENT_LIMIT;
        end else if (i_cmd < NEGATIVE_CURRENT_LIMIT) begin
            i_cmd = NEGATIVE_CURRENT_LIMIT;
        end
        v_cmd = sat32(48'(dz) * 48'(VELOCITY_SCALE_FACTOR));
        p_cmd = sat32(48'(dz) * 48'(POSITION_SCALE_FACTOR));

        next_loop = loop_q;
        next_mvel = mvel_q;
        next_filt = filt_q;
        if (sample_en) begin
            next_filt       = pole2;
            next_loop.valid = 1'b0;
            next_mvel.valid = 1'b0;
            if (set.func_select == FUNC_LOOP_CMD && COMMAND_SOURCE_SELECT == SOURCE_ANALOG) begin
                next_loop.valid = 1'b1;
                case (DRIVE_OPERATING_MODE)
                    OPMODE_TORQUE:   next_loop.value = i_cmd;
                    OPMODE_VELOCITY: next_loop.value = v_cmd;
                    OPMODE_POSITION: next_loop.value = p_cmd;
                    default:         next_loop.valid = 1'b0;
                endcase
            end
            if (set.func_select == FUNC_MOTION_VEL && DRIVE_OPERATING_MODE == OPMODE_POSITION &&
                COMMAND_SOURCE_SELECT == SOURCE_SERVICE) begin
                next_mvel.valid = 1'b1;
                next_mvel.value = v_cmd;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            loop_q      <= '0;
            mvel_q      <= '0;
            filt_q      <= 16'sh0000;
            SAMPLE_TICK <= 1'b0;
        end else begin
            loop_q      <= next_loop;
            mvel_q      <= next_mvel;
            filt_q      <= next_filt;
            SAMPLE_TICK <= sample_en;
        end
    end

    assign AIN_FILTERED     = filt_q;
    assign LOOP_CMD         = loop_q.value;
    assign LOOP_CMD_VALID   = loop_q.valid;
    assign MOTION_VEL       = mvel_q.value;
    assign MOTION_VEL_VALID = mvel_q.valid;
endmodule // acn_conditioner

// file: dv/acn_far_end.sv
// Analog command source and loop-side capture for the conditioner bench
`timescale 1ns/1ps
module acn_far_end
    import acn_pkg::*;
(
    input  wire logic               clk,
    input  wire logic signed [15:0] level,
    input  wire logic               tick,
    input  wire logic signed [31:0] cmd,
    output logic signed [15:0]      ain = 16'sh0000,
    output logic signed [31:0]      last_cmd = 32'sh0
);
    // Source changes only after an edge, like a sampled converter
    always @(posedge clk) begin
        ain <= level;
        if (tick) begin
            last_cmd <= cmd;
        end
    end
endmodule // acn_far_end

// file: dv/acn_conditioner_assertions.sv
// Port assertions for the analog command conditioner
`timescale 1ns/1ps
module acn_conditioner_checker
    import acn_pkg::*;
(
    input wire logic               REF_CLK,
    input wire logic               RSTN,
    input wire logic               REG_WR,
    input wire logic [15:0]        REG_ADDR,
    input wire logic [31:0]        REG_WDATA,
    input wire logic [31:0]        REG_RDATA,
    input wire logic [1:0]         DRIVE_OPERATING_MODE,
    input wire logic [1:0]         COMMAND_SOURCE_SELECT,
    input wire logic signed [31:0] NEGATIVE_CURRENT_LIMIT,
    input wire logic signed [31:0] POSITIVE_CURRENT_LIMIT,
    input wire logic signed [15:0] AIN_FILTERED,
    input wire logic signed [31:0] LOOP_CMD,
    input wire logic               LOOP_CMD_VALID,
    input wire logic               MOTION_VEL_VALID,
    input wire logic               SAMPLE_TICK
);
    logic [9:0] gap;
    logic       seen;
    logic [1:0] func;
    logic [9:0] next_gap;
    logic       next_seen;
    logic [1:0] next_func;
    // Shadow of the function setting; out-of-range writes are dropped as in the device
    always_comb begin
        next_gap = SAMPLE_TICK ? 10'h000 : gap + 10'h001;
        next_seen = seen | SAMPLE_TICK;
        next_func = func;
        if (REG_WR && REG_ADDR == ADDR_FUNC_SELECT && REG_WDATA[7:0] <= 8'h02) begin
            next_func = REG_WDATA[1:0];
        end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            gap <= 10'h000;
            seen <= 1'b0;
            func <= FUNC_RESET;
        end else begin
            gap <= next_gap;
            seen <= next_seen;
            func <= next_func;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_wr_corner;
        REG_WR && REG_ADDR == ADDR_CORNER_FREQ && REG_WDATA <= 32'h0000_2710;
    endsequence
    sequence s_hold_corner;
        !REG_WR && REG_ADDR == ADDR_CORNER_FREQ;
    endsequence
    AST_RD_BACK: assert property (s_wr_corner ##1 s_hold_corner |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("corner readback wrong");
    AST_TICK_PULSE: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
        else $error("tick longer than one cycle");
    AST_TICK_PERIOD: assert property (SAMPLE_TICK && seen |-> gap == 10'h13F)
        else $error("tick spacing wrong");
    AST_OUT_HOLD: assert property (!SAMPLE_TICK |-> $stable(LOOP_CMD) && $stable(AIN_FILTERED))
        else $error("output moved between samples");
    AST_CLAMP: assert property (SAMPLE_TICK && LOOP_CMD_VALID && $past(DRIVE_OPERATING_MODE) == OPMODE_TORQUE
        |-> LOOP_CMD <= $past(POSITIVE_CURRENT_LIMIT) && LOOP_CMD >= $past(NEGATIVE_CURRENT_LIMIT))
        else $error("current command outside limits");
    AST_FUNC_OFF: assert property (SAMPLE_TICK && $past(func) == FUNC_OFF |-> !LOOP_CMD_VALID && !MOTION_VEL_VALID)
        else $error("disabled input still feeds a command");
    AST_LOOP_VALID: assert property (SAMPLE_TICK && $past(func) == FUNC_LOOP_CMD |-> LOOP_CMD_VALID ==
        ($past(COMMAND_SOURCE_SELECT) == SOURCE_ANALOG && $past(DRIVE_OPERATING_MODE) != 2'h3))
        else $error("loop command valid wrong");
    AST_MOTION_VALID: assert property (SAMPLE_TICK && $past(func) == FUNC_MOTION_VEL |-> !LOOP_CMD_VALID &&
        MOTION_VEL_VALID == ($past(DRIVE_OPERATING_MODE) == OPMODE_POSITION && $past(COMMAND_SOURCE_SELECT) == 2'h0))
        else $error("motion velocity valid wrong");
    AST_ZERO_IN: assert property (SAMPLE_TICK && LOOP_CMD_VALID && AIN_FILTERED == 16'sh0000 |-> LOOP_CMD == 32'sh0)
        else $error("zero input gave nonzero command");
    AST_SIGN: assert property (SAMPLE_TICK && LOOP_CMD_VALID && $past(DRIVE_OPERATING_MODE) == OPMODE_TORQUE
        && AIN_FILTERED < 16'sh0000 |-> LOOP_CMD <= 32'sh0)
        else $error("negative input lost its sign");
endmodule // acn_conditioner_checker
bind acn_conditioner acn_conditioner_checker chk_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .DRIVE_OPERATING_MODE(DRIVE_OPERATING_MODE),
    .COMMAND_SOURCE_SELECT(COMMAND_SOURCE_SELECT), .NEGATIVE_CURRENT_LIMIT(NEGATIVE_CURRENT_LIMIT),
    .POSITIVE_CURRENT_LIMIT(POSITIVE_CURRENT_LIMIT), .AIN_FILTERED(AIN_FILTERED), .LOOP_CMD(LOOP_CMD),
    .LOOP_CMD_VALID(LOOP_CMD_VALID), .MOTION_VEL_VALID(MOTION_VEL_VALID), .SAMPLE_TICK(SAMPLE_TICK));

// file: dv/acn_conditioner_tb.sv
// Self-checking bench for the analog command conditioner
`timescale 1ns/1ps
module acn_conditioner_tb;
    import acn_pkg::*;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               reg_wr = 1'b0;
    logic [15:0]        addr = 16'h0000;
    logic [31:0]        wdata = 32'h0;
    logic [1:0]         mode = OPMODE_TORQUE;
    logic [1:0]         src = SOURCE_ANALOG;
    logic signed [31:0] vscale = 32'sh3;
    logic signed [31:0] pscale = 32'sh5;
    logic signed [31:0] nlim = -32'sh16E360;
    logic signed [31:0] plim = 32'sh16E360;
    logic signed [15:0] level = 16'sh0000;
    logic signed [15:0] ain;
    logic [31:0]        rdata;
    logic signed [15:0] filt;
    logic signed [31:0] cmd;
    logic signed [31:0] mvel;
    logic signed [31:0] seen_cmd;
    logic               cmd_v;
    logic               mvel_v;
    logic               tick;
    int                 miscompares = 0;
    int                 num_checks = 0;
    always #25 clk = ~clk;
    acn_conditioner uut (.REF_CLK(clk), .RSTN(rstn), .AIN_SAMPLE(ain), .REG_WR(reg_wr), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .DRIVE_OPERATING_MODE(mode), .COMMAND_SOURCE_SELECT(src),
        .VELOCITY_SCALE_FACTOR(vscale), .POSITION_SCALE_FACTOR(pscale), .NEGATIVE_CURRENT_LIMIT(nlim),
        .POSITIVE_CURRENT_LIMIT(plim), .AIN_FILTERED(filt), .LOOP_CMD(cmd), .LOOP_CMD_VALID(cmd_v),
        .MOTION_VEL(mvel), .MOTION_VEL_VALID(mvel_v), .SAMPLE_TICK(tick));
    acn_far_end fm (.clk(clk), .level(level), .tick(tick), .cmd(cmd), .ain(ain), .last_cmd(seen_cmd));
    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Tolerance absorbs the last-bit rounding of the recursive filter
    task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp, input logic signed [31:0] tol);
        num_checks++;
        if (((got - exp) <= tol && (exp - got) <= tol) !== 1'b1) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic ticks(input int n);
        for (int i = 0; i < n; i++) begin
            int k;
            k = 0;
            do begin
                @(posedge clk);
                #1;
                k++;
            end while (tick !== 1'b1 && k < 400);
            if (k >= 400) begin
                miscompares++;
                end_sim();
            end
            @(posedge clk);
            #1;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
        chk(rdata, e, 32'sh0);
    endtask
    task automatic set(input logic [1:0] m, input logic [1:0] s);
        @(posedge clk);
        mode <= m;
        src <= s;
    endtask
    task automatic t_defaults();
        rd(ADDR_CORNER_FREQ, 32'h1388);
        rd(ADDR_DEAD_ZONE_TH, 32'h0);
        rd(ADDR_CURRENT_SCALE, 32'h1);
        rd(ADDR_DEAD_ZONE_BHV, 32'h0);
        rd(ADDR_FUNC_SELECT, 32'h1);
        rd(ADDR_INPUT_OFFSET, 32'h0);
        rd(16'h0008, 32'h0);
    endtask
    task automatic t_ranges();
        wr(ADDR_DEAD_ZONE_TH, 32'h4E20);
        rd(ADDR_DEAD_ZONE_TH, 32'h30D4);
        wr(ADDR_CURRENT_SCALE, 32'h0);
        rd(ADDR_CURRENT_SCALE, 32'h1);
        wr(ADDR_CURRENT_SCALE, 32'h7530);
        rd(ADDR_CURRENT_SCALE, 32'h5780);
        wr(ADDR_DEAD_ZONE_BHV, 32'h2);
        rd(ADDR_DEAD_ZONE_BHV, 32'h0);
        wr(ADDR_FUNC_SELECT, 32'h3);
        rd(ADDR_FUNC_SELECT, 32'h1);
        wr(16'h0008, 32'h5);
        rd(16'h0008, 32'h0);
        wr(ADDR_CORNER_FREQ, 32'h4E20);
        rd(ADDR_CORNER_FREQ, 32'h2710);
    endtask
    task automatic t_torque();
        logic               b [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        logic signed [15:0] x [8] = '{16'sh01F4, 16'sh04B0, -16'sh04B0, 16'sh07D0, -16'sh07D0, 16'sh0320,
                                      16'sh1388, -16'sh1388};
        logic signed [31:0] e [8] = '{32'sh0, 32'sh124F80, -32'sh124F80, 32'shF4240, -32'shF4240, 32'sh0,
                                      32'sh16E360, -32'sh16E360};
        wr(ADDR_DEAD_ZONE_TH, 32'h3E8);
        wr(ADDR_CURRENT_SCALE, 32'h3E8);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_DEAD_ZONE_BHV, {31'h0, b[i]});
            level <= x[i];
            ticks(5);
            chk(seen_cmd, e[i], 32'sh3E8);
        end
        wr(ADDR_INPUT_OFFSET, 32'h12C);
        wr(ADDR_DEAD_ZONE_BHV, 32'h0);
        level <= 16'sh03E8;
        ticks(5);
        chk(seen_cmd, 32'sh13D620, 32'sh3E8);
        chk({31'h0, cmd_v}, 32'sh1, 32'sh0);
        wr(ADDR_INPUT_OFFSET, 32'h0);
    endtask
    task automatic t_modes();
        wr(ADDR_DEAD_ZONE_TH, 32'h0);
        level <= 16'sh07D0;
        set(OPMODE_VELOCITY, SOURCE_ANALOG);
        ticks(5);
        chk(cmd, 32'sh1770, 32'sh3);
        set(OPMODE_POSITION, SOURCE_ANALOG);
        ticks(2);
        chk(cmd, 32'sh2710, 32'sh5);
        set(OPMODE_POSITION, SOURCE_SERVICE);
        ticks(2);
        chk({31'h0, cmd_v}, 32'sh0, 32'sh0);
        wr(ADDR_FUNC_SELECT, 32'h2);
        ticks(2);
        chk(mvel, 32'sh1770, 32'sh3);
        chk({31'h0, mvel_v}, 32'sh1, 32'sh0);
        wr(ADDR_FUNC_SELECT, 32'h0);
        ticks(2);
        chk({30'h0, cmd_v, mvel_v}, 32'sh0, 32'sh0);
        wr(ADDR_FUNC_SELECT, 32'h1);
        set(OPMODE_TORQUE, SOURCE_ANALOG);
    endtask
    // A zero corner must hold the filter, then a mid corner shows a gradual two-pole decay
    task automatic t_filter();
        wr(ADDR_CORNER_FREQ, 32'h0);
        level <= 16'sh0000;
        ticks(5);
        chk(filt, 32'sh7D0, 32'sh1);
        wr(ADDR_CORNER_FREQ, 32'h9C4);
        ticks(4);
        chk(filt, 32'sh3E8, 32'sh3A2);
        ticks(40);
        chk(filt, 32'sh0, 32'sh3);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_defaults();
        t_ranges();
        t_torque();
        t_modes();
        t_filter();
        end_sim();
    end
endmodule // acn_conditioner_tb
